/* hdl/dsq_regs.vh */
// register map, field positions and step counts of the divide/root unit
`ifndef DSQ_REGS_VH
`define DSQ_REGS_VH

// --------------------------------------------------------------
// byte offsets
// --------------------------------------------------------------
`define DSQ_OFF_CSR 32'h0000_0000
`define DSQ_OFF_DEND 32'h0000_0004
`define DSQ_OFF_DIVISOR 32'h0000_0008
`define DSQ_OFF_RESULT 32'h0000_000c
`define DSQ_OFF_RCND 32'h0000_0010

// --------------------------------------------------------------
// control_status_register fields
// --------------------------------------------------------------
`define DSQ_BIT_START 0
`define DSQ_BIT_USGN 1
`define DSQ_BIT_REM 2
`define DSQ_BIT_TRAP_EN 3
`define DSQ_BIT_ZFLAG 4
`define DSQ_BIT_NRM 5
`define DSQ_BIT_SQRT 29
`define DSQ_BIT_DIV 30
`define DSQ_BIT_BUSY 31

// --------------------------------------------------------------
// reset values and step counts
// --------------------------------------------------------------
`define DSQ_RST_WORD 32'h0000_0000
`define DSQ_RST_ROOT 16'h0000
`define DSQ_DIV_STEPS 6'h20
`define DSQ_SQRT_STEPS 6'h10
`define DSQ_CNT_DONE 6'h00

`endif

/* hdl/dsq_engine.v */
// iterative divider and square root engine, one result bit per cycle
`timescale 1ns/1ps
`include "dsq_regs.vh"

module dsq_engine (
	input wire clk_i,          // system clock
	input wire rst_i,          // synchronous reset, active high
	input wire go_div_i,       // start pulse, division
	input wire go_sqrt_i,      // start pulse, square root
	input wire sgn_i,          // division is signed
	input wire [31:0] a_i,     // dividend or radicand
	input wire [31:0] b_i,     // divisor, nonzero
	output reg busy_o,         // operation running
	output reg done_o,         // one-cycle pulse, results valid
	output reg [31:0] quo_o,   // quotient
	output reg [31:0] rem_o,   // remainder
	output reg [15:0] root_o   // square root
);

// --------------------------------------------------------------
// helpers
// --------------------------------------------------------------
function [31:0] mag;
	input [31:0] v;
	input s;
	begin
		mag = (s && v[31]) ? (32'h0 - v) : v;
	end
endfunction

reg [31:0] acc;
reg [31:0] sh;
reg [31:0] dvs;
reg [15:0] rt;
reg [5:0] cnt;
reg is_sqrt;
reg neg_q;
reg neg_r;

wire [32:0] dtrial = {acc, sh[31]} - {1'b0, dvs};
wire [19:0] strial = {1'b0, acc[16:0], sh[31:30]} - {2'b00, rt, 2'b01};

// --------------------------------------------------------------
// sequencer
// --------------------------------------------------------------
always @(posedge clk_i) begin
	done_o <= 1'b0;
	if (rst_i) begin
		busy_o <= 1'b0;
		acc <= `DSQ_RST_WORD;
		sh <= `DSQ_RST_WORD;
		dvs <= `DSQ_RST_WORD;
		rt <= `DSQ_RST_ROOT;
		cnt <= `DSQ_CNT_DONE;
		is_sqrt <= 1'b0;
		neg_q <= 1'b0;
		neg_r <= 1'b0;
		quo_o <= `DSQ_RST_WORD;
		rem_o <= `DSQ_RST_WORD;
		root_o <= `DSQ_RST_ROOT;
	end else if (!busy_o && go_div_i) begin
		busy_o <= 1'b1;
		is_sqrt <= 1'b0;
		acc <= `DSQ_RST_WORD;
		sh <= mag(a_i, sgn_i);
		dvs <= mag(b_i, sgn_i);
		neg_q <= sgn_i & (a_i[31] ^ b_i[31]);
		neg_r <= sgn_i & a_i[31];
		cnt <= `DSQ_DIV_STEPS;
	end else if (!busy_o && go_sqrt_i) begin
		busy_o <= 1'b1;
		is_sqrt <= 1'b1;
		acc <= `DSQ_RST_WORD;
		sh <= a_i;
		rt <= `DSQ_RST_ROOT;
		cnt <= `DSQ_SQRT_STEPS;
	end else if (busy_o && cnt != `DSQ_CNT_DONE) begin
		cnt <= cnt - 6'h01;
		if (is_sqrt) begin
			sh <= {sh[29:0], 2'b00};
			if (!strial[19]) begin
				acc <= {13'h0, strial[18:0]};
				rt <= {rt[14:0], 1'b1};
			end else begin
				acc <= {13'h0, acc[16:0], sh[31:30]};
				rt <= {rt[14:0], 1'b0};
			end
		end else if (!dtrial[32]) begin
			acc <= dtrial[31:0];
			sh <= {sh[30:0], 1'b1};
		end else begin
			acc <= {acc[30:0], sh[31]};
			sh <= {sh[30:0], 1'b0};
		end
	end else if (busy_o) begin
		// final cycle: sign fix-up and result hand-off
		busy_o <= 1'b0;
		done_o <= 1'b1;
		if (is_sqrt) begin
			root_o <= rt;
		end else begin
			quo_o <= neg_q ? (32'h0 - sh) : sh;
			rem_o <= neg_r ? (32'h0 - acc) : acc;
		end
	end
end

endmodule // dsq_engine

/* hdl/dsq_unit.v */
// divide and square root unit with a classic wishbone register slave
//
// Operation
// - divides 32-bit operands, signed or unsigned per the mode bit
// - one division yields quotient and remainder, both readable
// - square root of a 32-bit unsigned radicand gives 16 bits
// - status shows busy or idle and last operation kind
// - select zero: writing the divisor starts division
// - select one: only a control write with start bit starts it
// - zero flag and trap enable set: result read ends in bus error
// - otherwise result read completes and returns stored contents
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "dsq_regs.vh"

module dsq_unit (
	input wire clk_i,          // system clock
	input wire rst_i,          // synchronous reset, active high
	input wire [31:0] adr_i,   // wishbone byte address
	input wire [31:0] dat_i,   // wishbone write data
	input wire [3:0] sel_i,    // wishbone byte enables
	input wire we_i,           // wishbone write
	input wire cyc_i,          // wishbone cycle
	input wire stb_i,          // wishbone strobe
	output reg [31:0] dat_o,   // wishbone read data
	output reg ack_o,          // wishbone normal end
	output reg err_o           // wishbone error end
);

// --------------------------------------------------------------
// helpers
// --------------------------------------------------------------
function [31:0] merge;
	input [31:0] old;
	input [31:0] nw;
	input [3:0] sel;
	integer i;
	begin
		merge = old;
		for (i = 0; i < 4; i = i + 1) begin
			if (sel[i]) begin
				merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	end
endfunction

// --------------------------------------------------------------
// state
// --------------------------------------------------------------
reg [31:0] dividend;
reg [31:0] divisor_register;
reg [31:0] radicand;
reg [31:0] quo;
reg [31:0] rem;
reg [15:0] root;
reg ctl_unsigned;
reg ctl_rem_sel;
reg zero_divisor_trap_enable;
reg zero_divisor_flag;
reg ctl_normal_start;
reg last_div;
reg last_sqrt;

wire eng_busy;
wire eng_done;
wire [31:0] eng_quo;
wire [31:0] eng_rem;
wire [15:0] eng_root;

// --------------------------------------------------------------
// address decode and bus handshake
// --------------------------------------------------------------
reg a_csr;
reg a_dend;
reg a_dvsr;
reg a_rslt;
reg a_rcnd;
reg a_none;

always @* begin
	a_csr = 1'b0;
	a_dend = 1'b0;
	a_dvsr = 1'b0;
	a_rslt = 1'b0;
	a_rcnd = 1'b0;
	a_none = 1'b0;
	if (adr_i == `DSQ_OFF_CSR) begin
		a_csr = 1'b1;
	end else if (adr_i == `DSQ_OFF_DEND) begin
		a_dend = 1'b1;
	end else if (adr_i == `DSQ_OFF_DIVISOR) begin
		a_dvsr = 1'b1;
	end else if (adr_i == `DSQ_OFF_RESULT) begin
		a_rslt = 1'b1;
	end else if (adr_i == `DSQ_OFF_RCND) begin
		a_rcnd = 1'b1;
	end else begin
		a_none = 1'b1;
	end
end

// busy covers the hand-off cycle, so a result read never sees stale data
wire op_busy = eng_busy | eng_done;
// only the control/status word may be touched while an operation runs
wire req = cyc_i & stb_i & ~ack_o & ~err_o;
wire stall = op_busy & ~a_csr;
wire take = req & ~stall;
wire wr = take & we_i;

// --------------------------------------------------------------
// readable words
// --------------------------------------------------------------
wire [31:0] csr_val = {op_busy, last_div, last_sqrt, 23'h0,
	ctl_normal_start, zero_divisor_flag, zero_divisor_trap_enable,
	ctl_rem_sel, ctl_unsigned, 1'b0};
wire [31:0] rslt_val = last_sqrt ? {16'h0, root} :
	(ctl_rem_sel ? rem : quo);

wire [31:0] csr_new = merge(csr_val, dat_i, sel_i);
wire [31:0] dvsr_new = merge(divisor_register, dat_i, sel_i);
wire [31:0] rcnd_new = merge(radicand, dat_i, sel_i);

wire wr_csr = wr & a_csr;
wire wr_dvsr = wr & a_dvsr;
wire go_fast = wr_dvsr & ~ctl_normal_start;
wire go_start = wr_csr & sel_i[0] & dat_i[`DSQ_BIT_START];
wire go_div = (go_fast | go_start) & ~op_busy;
wire go_sqrt = wr & a_rcnd & ~op_busy;
wire [31:0] op_b = wr_dvsr ? dvsr_new : divisor_register;
wire op_sgn = wr_csr ? ~csr_new[`DSQ_BIT_USGN] : ~ctl_unsigned;
wire b_zero = (op_b == `DSQ_RST_WORD);
wire trap = zero_divisor_flag & zero_divisor_trap_enable;

reg [31:0] rd_val;
always @* begin
	rd_val = `DSQ_RST_WORD;
	if (a_csr) begin
		rd_val = csr_val;
	end else if (a_dend) begin
		rd_val = dividend;
	end else if (a_dvsr) begin
		rd_val = divisor_register;
	end else if (a_rslt) begin
		rd_val = rslt_val;
	end else if (a_rcnd) begin
		rd_val = radicand;
	end
end

always @(posedge clk_i) begin
	if (rst_i) begin
		ack_o <= 1'b0;
		err_o <= 1'b0;
		dat_o <= `DSQ_RST_WORD;
	end else begin
		ack_o <= 1'b0;
		err_o <= 1'b0;
		if (take) begin
			if (a_none || (a_rslt && !we_i && trap)) begin
				err_o <= 1'b1;
			end else begin
				ack_o <= 1'b1;
			end
			if (!we_i) begin
				dat_o <= rd_val;
			end
		end
	end
end

// --------------------------------------------------------------
// registers and operation control
// --------------------------------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		dividend <= `DSQ_RST_WORD;
		divisor_register <= `DSQ_RST_WORD;
		radicand <= `DSQ_RST_WORD;
		quo <= `DSQ_RST_WORD;
		rem <= `DSQ_RST_WORD;
		root <= `DSQ_RST_ROOT;
		ctl_unsigned <= 1'b0;
		ctl_rem_sel <= 1'b0;
		zero_divisor_trap_enable <= 1'b0;
		zero_divisor_flag <= 1'b0;
		ctl_normal_start <= 1'b0;
		last_div <= 1'b0;
		last_sqrt <= 1'b0;
	end else begin
		if (wr && a_dend) begin
			dividend <= merge(dividend, dat_i, sel_i);
		end
		if (wr_dvsr) begin
			divisor_register <= dvsr_new;
		end
		if (wr && a_rcnd) begin
			radicand <= rcnd_new;
		end
		if (wr_csr) begin
			ctl_unsigned <= csr_new[`DSQ_BIT_USGN];
			ctl_rem_sel <= csr_new[`DSQ_BIT_REM];
			zero_divisor_trap_enable <= csr_new[`DSQ_BIT_TRAP_EN];
			ctl_normal_start <= csr_new[`DSQ_BIT_NRM];
		end
		if (go_div) begin
			last_div <= 1'b1;
			last_sqrt <= 1'b0;
			zero_divisor_flag <= b_zero;
			if (b_zero) begin
				// no iteration: quotient zero, remainder is the dividend
				quo <= `DSQ_RST_WORD;
				rem <= dividend;
			end
		end else if (go_sqrt) begin
			last_div <= 1'b0;
			last_sqrt <= 1'b1;
			zero_divisor_flag <= 1'b0;
		end
		if (eng_done) begin
			quo <= eng_quo;
			rem <= eng_rem;
			root <= eng_root;
		end
	end
end

dsq_engine u_engine (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.go_div_i(go_div & ~b_zero),
	.go_sqrt_i(go_sqrt),
	.sgn_i(op_sgn),
	.a_i(go_sqrt ? rcnd_new : dividend),
	.b_i(op_b),
	.busy_o(eng_busy),
	.done_o(eng_done),
	.quo_o(eng_quo),
	.rem_o(eng_rem),
	.root_o(eng_root)
);

endmodule // dsq_unit

/* testbench/dsq_unit_asserts.sv */
// bus and status checks of the divide/root unit
`timescale 1ns/1ps
module dsq_unit_asserts (
	input wire clk_i,        // clock
	input wire rst_i,        // reset
	input wire [31:0] adr_i, // address
	input wire [31:0] dat_i, // write data
	input wire [3:0] sel_i,  // byte enables
	input wire we_i,         // write
	input wire cyc_i,        // cycle
	input wire stb_i,        // strobe
	input wire [31:0] dat_o, // read data
	input wire ack_o,        // normal end
	input wire err_o         // error end
);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic trap_en;
	wire req = cyc_i && stb_i && !ack_o && !err_o;
	// last trap enable written to the control word
	always @(posedge clk_i)
		if (rst_i)
			trap_en <= 1'b0;
		else if (ack_o && we_i && adr_i == 32'h0 && sel_i[0])
			trap_en <= dat_i[3];
	property p_excl; !(ack_o && err_o); endproperty
	a_excl: assert property (p_excl)
		else $error("ack and err together");
	property p_ack_pulse; ack_o |=> !ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	property p_err_pulse; err_o |=> !err_o && !ack_o; endproperty
	a_err_pulse: assert property (p_err_pulse)
		else $error("err longer than one cycle");
	property p_cause; ack_o || err_o |-> $past(cyc_i && stb_i); endproperty
	a_cause: assert property (p_cause)
		else $error("answer without request");
	property p_csr; req && adr_i == 32'h0 |=> ack_o; endproperty
	a_csr: assert property (p_csr)
		else $error("control access not answered next cycle");
	property p_unmap; req && adr_i > 32'h10 |-> ##[1:40] err_o; endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped access without err");
	property p_status;
		ack_o && !we_i && adr_i == 32'h0 |-> !dat_o[0] &&
		dat_o[31:29] != 3'b100 && dat_o[30:29] != 2'b11;
	endproperty
	a_status: assert property (p_status)
		else $error("illegal status code");
	property p_trap; err_o && adr_i == 32'hc |-> trap_en; endproperty
	a_trap: assert property (p_trap)
		else $error("result err with trap off");
	property p_hold; !(ack_o || err_o) || we_i |-> $stable(dat_o); endproperty
	a_hold: assert property (p_hold)
		else $error("read data moved without read");
	c_trap: cover property (err_o && adr_i == 32'hc);
	c_busy: cover property (ack_o && !we_i && adr_i == 32'h0 && dat_o[31]);
	c_stall: cover property (req && adr_i == 32'hc ##1 !ack_o ##1 !ack_o);
endmodule // dsq_unit_asserts

/* testbench/dsq_cpu_model.sv */
// classic bus master standing in for the processor core
`timescale 1ns/1ps
module dsq_cpu_model (
	input wire clk_i,          // clock
	input wire [31:0] dat_i,   // read data
	input wire ack_i,          // normal end
	input wire err_i,          // error end
	output logic [31:0] adr_o, // address
	output logic [31:0] dat_o, // write data
	output logic [3:0] sel_o,  // byte enables
	output logic we_o,         // write
	output logic cyc_o,        // cycle
	output logic stb_o         // strobe
);
	// ----------------------------------------
	// transfer
	// ----------------------------------------
	initial begin
		adr_o = 32'h0;
		dat_o = 32'h0;
		sel_o = 4'hf;
		we_o = 1'b0;
		cyc_o = 1'b0;
		stb_o = 1'b0;
	end
	// rsp: 01 ack, 10 err, 00 no answer
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic [1:0] rsp);
		int n;
		@(posedge clk_i);
		adr_o <= a;
		dat_o <= wd;
		we_o <= w;
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		rsp = 2'b00;
		for (n = 0; n < 100 && rsp == 2'b00; n++) begin
			@(posedge clk_i);
			rsp = {err_i, ack_i};
		end
		rd = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
		// released lines stop showing the old values
		adr_o <= ~a;
		dat_o <= ~wd;
	endtask
endmodule // dsq_cpu_model

/* testbench/dsq_unit_tb.sv */
// self-checking bench of the divide/root unit
`timescale 1ns/1ps
module dsq_unit_tb;
	// ----------------------------------------
	// harness
	// ----------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	wire [31:0] adr, wdat, rdat;
	wire [3:0] sel;
	wire we, cyc, stb, ack, err;
	int num_errors = 0;
	int checked = 0;
	always #10 clk_i = ~clk_i;
	dsq_cpu_model cpu (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .err_i(err),
		.adr_o(adr), .dat_o(wdat), .sel_o(sel), .we_o(we), .cyc_o(cyc),
		.stb_o(stb));
	dsq_unit dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
		.sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(rdat),
		.ack_o(ack), .err_o(err));
	task automatic chk_dat(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_rsp(input logic [1:0] g, input logic [1:0] e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic [1:0] s;
		cpu.xfer(1'b1, {24'h0, a}, d, r, s);
		chk_rsp(s, 2'b01);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] es);
		logic [31:0] r;
		logic [1:0] s;
		cpu.xfer(1'b0, {24'h0, a}, 32'h0, r, s);
		chk_rsp(s, es);
		if (es == 2'b01)
			chk_dat(r, e);
	endtask
	task automatic finish_test;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		finish_test;
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(8'h0, 32'h0, 2'b01);
		rd(8'h14, 32'h0, 2'b10);
		wr(8'h0, 32'h2);
		wr(8'h4, 32'h64);
		wr(8'h8, 32'h7);
		rd(8'h0, 32'hc000_0002, 2'b01);
		rd(8'hc, 32'he, 2'b01);
		wr(8'h0, 32'h6);
		rd(8'hc, 32'h2, 2'b01);
		rd(8'h0, 32'h4000_0006, 2'b01);
		wr(8'h0, 32'h0);
		wr(8'h4, 32'hffff_ff9c);
		wr(8'h8, 32'h7);
		rd(8'hc, 32'hffff_fff2, 2'b01);
		wr(8'h0, 32'h4);
		rd(8'hc, 32'hffff_fffe, 2'b01);
		wr(8'h0, 32'h20);
		wr(8'h4, 32'h32);
		wr(8'h8, 32'h5);
		rd(8'h0, 32'h4000_0020, 2'b01);
		rd(8'hc, 32'hffff_fff2, 2'b01);
		wr(8'h0, 32'h21);
		rd(8'h0, 32'hc000_0020, 2'b01);
		rd(8'hc, 32'ha, 2'b01);
		wr(8'h10, 32'h000f_4240);
		rd(8'h0, 32'ha000_0020, 2'b01);
		rd(8'hc, 32'h3e8, 2'b01);
		rd(8'h0, 32'h2000_0020, 2'b01);
		wr(8'h10, 32'hffff_ffff);
		rd(8'hc, 32'hffff, 2'b01);
		wr(8'h0, 32'h8);
		wr(8'h4, 32'h9);
		wr(8'h8, 32'h0);
		rd(8'h0, 32'h4000_0018, 2'b01);
		rd(8'hc, 32'h0, 2'b10);
		rd(8'hc, 32'h0, 2'b10);
		wr(8'h0, 32'h0);
		rd(8'hc, 32'h0, 2'b01);
		rd(8'h0, 32'h4000_0010, 2'b01);
		wr(8'h8, 32'h3);
		rd(8'h0, 32'hc000_0000, 2'b01);
		wr(8'hc, 32'h5a5a_5a5a);
		rd(8'hc, 32'h3, 2'b01);
		wr(8'h4, 32'h8000_0000);
		wr(8'h8, 32'hffff_ffff);
		rd(8'hc, 32'h8000_0000, 2'b01);
		finish_test;
	end
endmodule // dsq_unit_tb

bind dsq_unit dsq_unit_asserts chk (.clk_i(clk_i), .rst_i(rst_i),
	.adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o));
